// ==== logic/pcmg_cfg.svh ====
// Constants of the clock mode generator: offsets, field positions, reset and timing values
`ifndef PCMG_CFG_SVH
`define PCMG_CFG_SVH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define PCMG_ADDR_W 16
`define PCMG_DATA_W 16
`define PCMG_CTRL_OFFSET 16'h0058

// ----------------------------------------------------------------
// Field positions of clock_mode_control
// ----------------------------------------------------------------
`define PCMG_MUL_HI 15
`define PCMG_MUL_LO 12
`define PCMG_FRAC_BIT 11
`define PCMG_CNT_HI 10
`define PCMG_CNT_LO 3
`define PCMG_FORCE_BIT 2
`define PCMG_SEL_BIT 1
`define PCMG_STATUS_BIT 0

// ----------------------------------------------------------------
// Reset values: bypass setting, loop mode, ratio of one
// ----------------------------------------------------------------
`define PCMG_RST_MUL 4'hf
`define PCMG_RST_FRAC 1'h0
`define PCMG_RST_CNT 8'h00
`define PCMG_RST_FORCE 1'h0
`define PCMG_RST_SEL 1'h1

// ----------------------------------------------------------------
// Ratio codes and timing
// ----------------------------------------------------------------
`define PCMG_MUL_MAX 4'hf
`define PCMG_Q_HALF 7'h02
`define PCMG_Q_QUARTER 7'h01
`define PCMG_Q_ONE 7'h04
`define PCMG_REF_PRESCALE 16

`endif

// ==== logic/pcmg_pkg.sv ====
// Types shared by the clock mode generator modules
`default_nettype none

package pcmg_pkg;

  // ----------------------------------------------------------------
  // Register bus request
  // ----------------------------------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic from_b;
    logic [15:0] addr;
    logic [15:0] wdata;
  } pcmg_bus_req_t;

  // ----------------------------------------------------------------
  // Software fields of clock_mode_control
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0] ratio_multiplier_field;
    logic fractional_ratio_bit;
    logic [7:0] lock_timer_preset;
    logic loop_force_on_bit;
    logic loop_mode_select;
  } pcmg_ctrl_t;

  // ----------------------------------------------------------------
  // Clock source state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PCMG_DIV_RUN,
    PCMG_LOCKING,
    PCMG_LOOP_RUN
  } pcmg_state_t;

endpackage : pcmg_pkg

`default_nettype wire

// ==== logic/pcmg_ref_sync.sv ====
// Reference clock synchroniser, period meter and divide-by-16 tick
`default_nettype none
`include "pcmg_cfg.svh"

module pcmg_ref_sync #(
  parameter int PERIOD_W = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Reference pin
  input wire logic reference_clock_in,
  // Derived events
  output logic ref_rise,
  output logic ref_div16_tick,
  output logic [PERIOD_W-1:0] ref_period
);
  import pcmg_pkg::*;

  localparam int PRE_W = $clog2(`PCMG_REF_PRESCALE);

  logic sync1;
  logic sync2;
  logic sync3;
  logic ref_level;
  logic next_ref_level;
  logic next_ref_rise;
  logic [PRE_W-1:0] pre_cnt;
  logic [PRE_W-1:0] next_pre_cnt;
  logic next_ref_div16_tick;
  logic [PERIOD_W-1:0] run_cnt;
  logic [PERIOD_W-1:0] next_run_cnt;
  logic [PERIOD_W-1:0] next_ref_period;

  // ----------------------------------------------------------------
  // Three-stage synchroniser; the first stage feeds only the second
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      sync3 <= 1'b0;
    end else begin
      sync1 <= reference_clock_in;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // ----------------------------------------------------------------
  // Edge, prescaler and period measurement
  // ----------------------------------------------------------------
  always_comb begin
    next_ref_level = (sync2 == sync3) ? sync3 : ref_level;
    next_ref_rise = next_ref_level && !ref_level;
    next_pre_cnt = pre_cnt;
    next_ref_div16_tick = 1'b0;
    next_ref_period = ref_period;
    next_run_cnt = (&run_cnt) ? run_cnt : run_cnt + 1'b1;
    if (next_ref_rise) begin
      next_pre_cnt = pre_cnt + 1'b1;
      // One tick per sixteen reference clocks
      next_ref_div16_tick = &pre_cnt;
      next_ref_period = next_run_cnt;
      next_run_cnt = '0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_level <= 1'b0;
      ref_rise <= 1'b0;
      pre_cnt <= '0;
      ref_div16_tick <= 1'b0;
      run_cnt <= '0;
      ref_period <= '0;
    end else begin
      ref_level <= next_ref_level;
      ref_rise <= next_ref_rise;
      pre_cnt <= next_pre_cnt;
      ref_div16_tick <= next_ref_div16_tick;
      run_cnt <= next_run_cnt;
      ref_period <= next_ref_period;
    end
  end

endmodule : pcmg_ref_sync

`default_nettype wire

// ==== logic/pcmg_synth.sv ====
// Numerically controlled clock synthesiser: output = reference * ratio_q / 4
`default_nettype none
`include "pcmg_cfg.svh"

module pcmg_synth #(
  parameter int PERIOD_W = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Measured reference period in clk cycles
  input wire logic [PERIOD_W-1:0] ref_period,
  // Ratio in quarters, zero stops the output
  input wire logic [6:0] ratio_q,
  // Synthesised clock
  output logic clk_out
);
  import pcmg_pkg::*;

  // Accumulator holds quarter-scaled periods plus headroom for one step
  localparam int ACC_W = PERIOD_W + 4;

  logic [ACC_W-1:0] acc;
  logic [ACC_W-1:0] next_acc;
  logic next_clk_out;
  logic [ACC_W-1:0] limit;
  logic [ACC_W-1:0] sum;

  // ----------------------------------------------------------------
  // Toggle each time half an output period has been accumulated.
  // Output cannot exceed half of clk; faster ratios saturate at that rate.
  // ----------------------------------------------------------------
  always_comb begin
    limit = {2'b00, ref_period, 2'b00};
    sum = acc + {{(ACC_W-8){1'b0}}, ratio_q, 1'b0};
    next_acc = sum;
    next_clk_out = clk_out;
    if (ref_period == '0 || ratio_q == '0) begin
      next_acc = '0;
      next_clk_out = 1'b0;
    end else if (sum >= limit) begin
      next_acc = sum - limit;
      next_clk_out = !clk_out;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc <= '0;
      clk_out <= 1'b0;
    end else begin
      acc <= next_acc;
      clk_out <= next_clk_out;
    end
  end

endmodule : pcmg_synth

`default_nettype wire

// ==== logic/pcmg_top.sv ====
// Clock mode generator: control register, lock timer, source selection and clock synthesis
// Function
// - Divider mode gives reference divided by two or four; loop may be off.
// - Loop mode multiplies the reference by one of thirty-one ratios.
// - Only subsystem A reaches the control register; subsystem B accesses are dropped.
// - Top four bits, fractional bit and mode select together choose the ratio.
// - Fractional bit set: (m+1)/2 for zero or even m, m/4 for odd m.
// - Lock timer loads the eight-bit preset, decrements once per sixteen reference clocks.
// - Oscillator is off only when force-on and mode select are both zero.
// - Mode select high requests loop mode, low requests divider mode.
// - Status bit reads zero in divider mode and one in loop mode.
// - In divider mode the preset field and fractional bit are don't-care for software; ratio picks half or quarter, force-on keeps the oscillator on.
// - Select clear: half the reference for m 0..14, quarter for m 15.
// - Select set, fraction clear: ratio m+1 for 0..14, bypass ratio one for 15.
// - Reset comes up in bypass: select set, fraction clear, multiplier 15.
// - Lock timer starts on divider-to-loop change; loop clock used after it reaches zero.
`default_nettype none
`include "pcmg_cfg.svh"

module pcmg_top #(
  parameter int PERIOD_W = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Reference oscillator pin
  input wire logic reference_clock_in,
  // Register port
  input wire pcmg_pkg::pcmg_bus_req_t bus_req,
  output logic [`PCMG_DATA_W-1:0] rd_data,
  // Clock outputs and state
  output logic device_clock_out,
  output logic loop_osc_on,
  output logic loop_clock_active
);
  import pcmg_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  pcmg_ctrl_t ctrl;
  pcmg_ctrl_t next_ctrl;
  pcmg_state_t state;
  pcmg_state_t next_state;
  logic [7:0] lock_cnt;
  logic [7:0] next_lock_cnt;
  logic sel_prev;
  logic next_sel_prev;
  logic [`PCMG_DATA_W-1:0] next_rd_data;
  logic next_loop_osc_on;
  logic next_loop_clock_active;
  logic [6:0] ratio_q;
  logic [6:0] next_ratio_q;
  logic ref_rise;
  logic ref_div16_tick;
  logic [PERIOD_W-1:0] ref_period;
  logic synth_clk;
  logic ctrl_hit;
  logic [`PCMG_DATA_W-1:0] ctrl_word;

  // ----------------------------------------------------------------
  // Reference conditioning; the oscillator itself is external
  // ----------------------------------------------------------------
  pcmg_ref_sync #(
    .PERIOD_W(PERIOD_W)
  ) u_ref_sync (
    .clk(clk),
    .rst_n(rst_n),
    .reference_clock_in(reference_clock_in),
    .ref_rise(ref_rise),
    .ref_div16_tick(ref_div16_tick),
    .ref_period(ref_period)
  );

  // ----------------------------------------------------------------
  // Register slave
  // ----------------------------------------------------------------
  // Subsystem B requests never match, so they neither write nor read
  assign ctrl_hit = (bus_req.addr == `PCMG_CTRL_OFFSET) && !bus_req.from_b;

  always_comb begin
    ctrl_word = '0;
    ctrl_word[`PCMG_MUL_HI:`PCMG_MUL_LO] = ctrl.ratio_multiplier_field;
    ctrl_word[`PCMG_FRAC_BIT] = ctrl.fractional_ratio_bit;
    ctrl_word[`PCMG_CNT_HI:`PCMG_CNT_LO] = ctrl.lock_timer_preset;
    ctrl_word[`PCMG_FORCE_BIT] = ctrl.loop_force_on_bit;
    ctrl_word[`PCMG_SEL_BIT] = ctrl.loop_mode_select;
    // Status follows the real source, not the request
    ctrl_word[`PCMG_STATUS_BIT] = (state == PCMG_LOOP_RUN);
  end

  always_comb begin
    next_ctrl = ctrl;
    next_rd_data = '0;
    if (bus_req.wr && ctrl_hit) begin
      // Status is hardware-owned; its write bit is ignored
      next_ctrl.ratio_multiplier_field = bus_req.wdata[`PCMG_MUL_HI:`PCMG_MUL_LO];
      next_ctrl.fractional_ratio_bit = bus_req.wdata[`PCMG_FRAC_BIT];
      next_ctrl.lock_timer_preset = bus_req.wdata[`PCMG_CNT_HI:`PCMG_CNT_LO];
      next_ctrl.loop_force_on_bit = bus_req.wdata[`PCMG_FORCE_BIT];
      next_ctrl.loop_mode_select = bus_req.wdata[`PCMG_SEL_BIT];
    end
    // Fields read back as stored even in divider mode; software ignores them
    if (bus_req.rd && ctrl_hit) begin
      next_rd_data = ctrl_word;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl.ratio_multiplier_field <= `PCMG_RST_MUL;
      ctrl.fractional_ratio_bit <= `PCMG_RST_FRAC;
      ctrl.lock_timer_preset <= `PCMG_RST_CNT;
      ctrl.loop_force_on_bit <= `PCMG_RST_FORCE;
      ctrl.loop_mode_select <= `PCMG_RST_SEL;
      rd_data <= '0;
    end else begin
      ctrl <= next_ctrl;
      rd_data <= next_rd_data;
    end
  end

  // ----------------------------------------------------------------
  // Source selection and lock timer
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_lock_cnt = lock_cnt;
    next_sel_prev = ctrl.loop_mode_select;
    unique case (state)
      PCMG_DIV_RUN: begin
        if (ctrl.loop_mode_select && !sel_prev) begin
          next_lock_cnt = ctrl.lock_timer_preset;
          next_state = PCMG_LOCKING;
        end
      end
      PCMG_LOCKING: begin
        // Divider clock keeps running throughout the count
        if (!ctrl.loop_mode_select) begin
          next_state = PCMG_DIV_RUN;
        end else if (lock_cnt == 8'h00) begin
          next_state = PCMG_LOOP_RUN;
        end else if (ref_div16_tick) begin
          next_lock_cnt = lock_cnt - 8'h01;
        end
      end
      PCMG_LOOP_RUN: begin
        if (!ctrl.loop_mode_select) begin
          next_state = PCMG_DIV_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= PCMG_LOOP_RUN;
      lock_cnt <= `PCMG_RST_CNT;
      sel_prev <= `PCMG_RST_SEL;
    end else begin
      state <= next_state;
      lock_cnt <= next_lock_cnt;
      sel_prev <= next_sel_prev;
    end
  end

  // ----------------------------------------------------------------
  // Ratio decode in quarters of the reference frequency
  // ----------------------------------------------------------------
  always_comb begin
    next_ratio_q = `PCMG_Q_HALF;
    if (state != PCMG_LOOP_RUN) begin
      // Divider mode, also used while the timer runs
      if (ctrl.ratio_multiplier_field == `PCMG_MUL_MAX) begin
        next_ratio_q = `PCMG_Q_QUARTER;
      end else begin
        next_ratio_q = `PCMG_Q_HALF;
      end
    end else if (!ctrl.fractional_ratio_bit) begin
      if (ctrl.ratio_multiplier_field == `PCMG_MUL_MAX) begin
        next_ratio_q = `PCMG_Q_ONE;
      end else begin
        next_ratio_q = {1'b0, ctrl.ratio_multiplier_field + 4'h1, 2'b00};
      end
    end else if (!ctrl.ratio_multiplier_field[0]) begin
      // (m+1)/2 is 2*(m+1) quarters
      next_ratio_q = {1'b0, {1'b0, ctrl.ratio_multiplier_field} + 5'h01, 1'b0};
    end else begin
      next_ratio_q = {3'b000, ctrl.ratio_multiplier_field};
    end
  end

  // ----------------------------------------------------------------
  // Oscillator enable and status outputs
  // ----------------------------------------------------------------
  always_comb begin
    next_loop_osc_on = ctrl.loop_force_on_bit || ctrl.loop_mode_select;
    next_loop_clock_active = (next_state == PCMG_LOOP_RUN);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ratio_q <= `PCMG_Q_ONE;
      loop_osc_on <= `PCMG_RST_SEL;
      loop_clock_active <= 1'b1;
    end else begin
      ratio_q <= next_ratio_q;
      loop_osc_on <= next_loop_osc_on;
      loop_clock_active <= next_loop_clock_active;
    end
  end

  // ----------------------------------------------------------------
  // Clock synthesis; registered output straight to the pin
  // ----------------------------------------------------------------
  pcmg_synth #(
    .PERIOD_W(PERIOD_W)
  ) u_synth (
    .clk(clk),
    .rst_n(rst_n),
    .ref_period(ref_period),
    .ratio_q(ratio_q),
    .clk_out(synth_clk)
  );

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      device_clock_out <= 1'b0;
    end else begin
      device_clock_out <= synth_clk;
    end
  end

endmodule : pcmg_top

`default_nettype wire

// ==== testbench/pcmg_top_monitor.sv ====
// Port-level checks of the clock mode generator
`default_nettype none

module pcmg_top_monitor
  import pcmg_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Reference and register port
  input wire logic reference_clock_in,
  input wire pcmg_bus_req_t bus_req,
  input wire logic [15:0] rd_data,
  // Clock outputs
  input wire logic device_clock_out,
  input wire logic loop_osc_on,
  input wire logic loop_clock_active
);
  logic ctrl_wr;
  logic ctrl_rd;
  logic prev_out;
  logic [7:0] hold;
  logic [7:0] next_hold;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  assign ctrl_wr = bus_req.wr && !bus_req.from_b && bus_req.addr == 16'h0058;
  assign ctrl_rd = bus_req.rd && !bus_req.from_b && bus_req.addr == 16'h0058;

  // Cycles since the device clock last changed; a stuck output lets it grow
  always_comb begin
    next_hold = (device_clock_out != prev_out) ? 8'h00 : hold + 8'h01;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_out <= 1'b0;
      hold <= 8'h00;
    end else begin
      prev_out <= device_clock_out;
      hold <= next_hold;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_rd_idle_zero: assert property (!bus_req.rd |=> rd_data == 16'h0000)
    else $error("read data not zero outside a read");
  a_rd_reject_zero: assert property (bus_req.rd && (bus_req.from_b ||
      bus_req.addr != 16'h0058) |=> rd_data == 16'h0000)
    else $error("refused read returned data");
  a_status_read: assert property (ctrl_rd |=> rd_data[0] == $past(loop_clock_active))
    else $error("status bit differs from clock source");
  a_osc_enable: assert property (ctrl_wr ##1 !bus_req.wr |=>
      loop_osc_on == ($past(bus_req.wdata[2], 2) || $past(bus_req.wdata[1], 2)))
    else $error("oscillator enable wrong");
  a_div_drop: assert property (ctrl_wr && !bus_req.wdata[1] |-> ##[1:3] !loop_clock_active)
    else $error("divider mode not entered");
  a_lock_zero_fast: assert property (ctrl_wr && bus_req.wdata[1] &&
      bus_req.wdata[10:3] == 8'h00 && !loop_clock_active |-> ##[1:6] loop_clock_active)
    else $error("zero preset did not switch to loop");
  a_lock_hold_div: assert property (ctrl_wr && bus_req.wdata[1] &&
      bus_req.wdata[10:4] != 7'h00 && !loop_clock_active |=> !loop_clock_active [*8])
    else $error("loop clock used before lock time");
  a_rise_needs_osc: assert property ($rose(loop_clock_active) |-> loop_osc_on)
    else $error("loop source chosen with oscillator off");
  a_clock_runs: assert property (hold < 8'd100)
    else $error("device clock stuck");
endmodule : pcmg_top_monitor

bind pcmg_top pcmg_top_monitor u_pcmg_top_monitor (.clk(clk), .rst_n(rst_n),
  .reference_clock_in(reference_clock_in), .bus_req(bus_req), .rd_data(rd_data),
  .device_clock_out(device_clock_out), .loop_osc_on(loop_osc_on),
  .loop_clock_active(loop_clock_active));

`default_nettype wire

// ==== testbench/pcmg_ref_osc.sv ====
// Free-running external reference oscillator
`default_nettype none

module pcmg_ref_osc #(
  parameter realtime HALF_NS = 100.0
) (
  // Reference pin
  output var logic reference_clock_in
);
  timeunit 1ns;
  timeprecision 1ps;

  // Odd start offset keeps the reference out of phase with the system clock
  initial begin
    reference_clock_in = 1'b0;
    #7.3;
    forever #(HALF_NS) reference_clock_in = ~reference_clock_in;
  end
endmodule : pcmg_ref_osc

`default_nettype wire

// ==== testbench/pcmg_top_tb.sv ====
// Self-checking bench of the clock mode generator
`default_nettype none

module pcmg_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import pcmg_pkg::*;

  localparam logic [15:0] CTRL = 16'h0058;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  wire ref_clk;
  pcmg_bus_req_t req = '0;
  logic [15:0] rd_data;
  logic dev_clk;
  logic osc_on;
  logic loop_act;
  logic [15:0] q;
  int mismatches = 0;
  int compares = 0;
  int cycles = 0;
  logic [15:0] words [5] = '{16'h0000, 16'hf004, 16'h2002, 16'h4802, 16'h3802};

  always #10 clk = ~clk;

  pcmg_ref_osc u_pcmg_ref_osc (.reference_clock_in(ref_clk));

  pcmg_top u_pcmg_top (.clk(clk), .rst_n(rst_n), .reference_clock_in(ref_clk),
    .bus_req(req), .rd_data(rd_data), .device_clock_out(dev_clk), .loop_osc_on(osc_on),
    .loop_clock_active(loop_act));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // One strobe cycle; read data is taken in the cycle after the strobe
  task automatic acc(input logic w, input logic b, input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    req <= '{wr: w, rd: !w, from_b: b, addr: a, wdata: d};
    @(posedge clk);
    req.wr <= 1'b0;
    req.rd <= 1'b0;
    #1 q = rd_data;
  endtask : acc

  // Ratio in quarters of the reference
  function automatic int rq(input logic [15:0] w);
    if (!w[1]) return (w[15:12] == 4'hf) ? 1 : 2;
    if (!w[11]) return (w[15:12] == 4'hf) ? 4 : 4 * (w[15:12] + 1);
    return w[12] ? int'(w[15:12]) : 2 * (w[15:12] + 1);
  endfunction : rq

  // 400 cycles span 40 reference periods, so edges expected are ten times the quarters
  task automatic edges(input logic [15:0] w);
    int n;
    logic prev;
    n = 0;
    prev = dev_clk;
    repeat (400) begin
      @(posedge clk);
      #1;
      if (dev_clk && !prev) n++;
      prev = dev_clk;
    end
    compares++;
    if (n < 10 * rq(w) - 3 || n > 10 * rq(w) + 3) begin
      mismatches++;
      $display("mismatch clock_edges expected %0d seen %0d", 10 * rq(w), n);
    end
  endtask : edges

  task automatic end_sim();
    if (mismatches == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_sim

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      end_sim();
    end
  end

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    acc(0, 0, CTRL, 16'h0000);
    chk("ctrl_reset", 16'hf003, q);
    repeat (100) @(posedge clk);
    edges(16'hf002);
    foreach (words[i]) begin
      acc(1, 0, CTRL, words[i]);
      repeat (100) @(posedge clk);
      #1 chk("osc_on", {15'h0, words[i][2] | words[i][1]}, {15'h0, osc_on});
      edges(words[i]);
      acc(0, 0, CTRL, 16'h0000);
      chk("status", {15'h0, words[i][1]}, {15'h0, q[0]});
      if (words[i][1]) chk("ctrl_back", words[i] | 16'h0001, q);
    end
    acc(1, 1, CTRL, 16'h0000);
    acc(0, 1, CTRL, 16'h0000);
    chk("read_from_b", 16'h0000, q);
    acc(1, 0, 16'h0059, 16'h0000);
    acc(0, 0, 16'h0059, 16'h0000);
    chk("read_unmapped", 16'h0000, q);
    acc(0, 0, CTRL, 16'h0000);
    chk("ctrl_kept", 16'h3803, q);
    // Lock timer of three ticks, each of sixteen reference periods
    acc(1, 0, CTRL, 16'h0000);
    repeat (10) @(posedge clk);
    acc(1, 0, CTRL, 16'h201a);
    acc(0, 0, CTRL, 16'h0000);
    chk("status_locking", 16'h0000, {15'h0, q[0]});
    repeat (280) @(posedge clk);
    #1 chk("active_early", 16'h0000, {15'h0, loop_act});
    for (int k = 0; k < 300 && loop_act !== 1'b1; k++) @(posedge clk);
    #1 chk("active_late", 16'h0001, {15'h0, loop_act});
    end_sim();
  end
endmodule : pcmg_top_tb

`default_nettype wire
